// ==== include/baud_gen_pkg.sv ====
// Package of constants and carrier types for the UART baud rate generator
package baud_gen_pkg;
   // ----------------------------------------
   // Register map (word offsets of the plain port)
   // ----------------------------------------
   localparam logic [1:0] BAUD_DIVIDER_CONTROL_ADDR = 2'h0;
   localparam logic [1:0] SERIAL_MODE_ADDR = 2'h1;
   localparam logic [1:0] TX_DATA_ADDR = 2'h2;
   localparam logic [1:0] STATUS_ADDR = 2'h3;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CLOCK_SELECT_HIGH_POS = 7;
   localparam int CLOCK_SELECT_LOW_POS = 6;
   localparam int DIVISOR_BIT_TOP_POS = 4;
   localparam int DIVISOR_BIT_BOTTOM_POS = 0;
   localparam int SERIAL_POWER_POS = 7;
   localparam int TRANSMIT_ENABLE_POS = 6;
   localparam int RECEIVE_ENABLE_POS = 5;
   localparam logic [7:0] BAUD_DIVIDER_CONTROL_RESET = 8'h1F;
   localparam logic [7:0] SERIAL_MODE_RESET = 8'h01;
   // ----------------------------------------
   // Clock select codes and timing
   // ----------------------------------------
   localparam logic [1:0] SEL_TIMER = 2'h0;
   localparam logic [1:0] SEL_DIV2 = 2'h1;
   localparam logic [1:0] SEL_DIV8 = 2'h2;
   localparam logic [1:0] SEL_DIV32 = 2'h3;
   localparam logic [4:0] DIVISOR_MIN = 5'h08;
   localparam logic [3:0] FRAME_BITS = 4'hB;
   localparam logic [4:0] PRESCALE_MAX = 5'h1F;
   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] clock_select;
      logic unused_bit;
      logic [4:0] divisor;
   } divider_ctrl_t;
   typedef struct packed {
      logic serial_power_bit;
      logic transmit_enable_bit;
      logic receive_enable_bit;
      logic [4:0] spare;
   } serial_mode_t;
   typedef enum logic [1:0] {RX_IDLE, RX_VERIFY, RX_FRAME} rx_state_t;
endpackage : baud_gen_pkg

// ==== logic/uart_baud_rate_generator.sv ====
// UART baud rate generator with separate transmit and receive bit-timing counters
`timescale 1ns/1ns
// Overview of operation
// (R01) Base clock gated by serial power bit
// (R02) Transmit counter held zero unless powered, enabled
// (R03) Transmit counter runs when power and enable
// (R04) First transmit write clears transmit counter
// (R05) Receive counter held zero unless powered, enabled
// (R06) Receive counter starts on start bit
// (R07) Receive counter idles after one frame
// (R08) Bits 7:6 select base clock source
// (R09) Bits 4:0 set divisor k, 8..31
// (R10) Bit time equals 2k base clocks
// (R11) Receiver latches bits by receive counter
// (R12) Latch margin two base clocks, 11-bit frame
// (R13) Software keeps transmit rate error acceptable
// (R14) Remote rate error within receivable limits
// (R15) Two independent five-bit counters
// (R16) Divisor below 8 unsupported
module uart_baud_rate_generator #(
   parameter int FRAME_LEN = 11
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_channel_output_in,
   input wire logic rxd_in,
   output logic [7:0] rdata_out,
   output logic base_clock_out,
   output logic tx_bit_tick_out,
   output logic rx_sample_out,
   output logic rx_bit_out,
   output logic rx_busy_out
);
   // ----------------------------------------
   // Registers and nets
   // ----------------------------------------
   baud_gen_pkg::divider_ctrl_t ctrl_reg;
   baud_gen_pkg::serial_mode_t mode_reg;
   logic [4:0] prescale_reg;
   logic timer_prev_reg;
   logic base_src;
   logic base_en;
   logic rxd_prev_reg;
   logic rx_start;
   logic [7:0] status_word;
   logic tx_run;
   logic rx_run;
   logic [4:0] tx_count_reg;
   logic tx_half_reg;
   logic tx_first_reg;
   logic [4:0] rx_count_reg;
   logic rx_half_reg;
   logic [3:0] rx_bits_reg;
   baud_gen_pkg::rx_state_t rx_state_reg;
   logic [4:0] k_last;
   logic tx_write;

   // Run conditions, divisor end point and data write decode
   assign tx_run = mode_reg.serial_power_bit & mode_reg.transmit_enable_bit;
   assign rx_run = mode_reg.serial_power_bit & mode_reg.receive_enable_bit;
   assign k_last = ctrl_reg.divisor - 5'h01;
   assign tx_write = wr_in & (addr_in == baud_gen_pkg::TX_DATA_ADDR);

   // Start bit: line seen falling between two base clocks
   assign rx_start = base_en & ~rxd_in & rxd_prev_reg; // [R06]

   // Status word: receive busy, first write pending, bits latched
   assign status_word = {rx_busy_out, tx_first_reg, 2'h0, rx_bits_reg};

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Software writes to control and mode registers
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ctrl_reg <= baud_gen_pkg::BAUD_DIVIDER_CONTROL_RESET;
         mode_reg <= baud_gen_pkg::SERIAL_MODE_RESET;
      end
      else if (wr_in)
      begin
         if (addr_in == baud_gen_pkg::BAUD_DIVIDER_CONTROL_ADDR)
         begin
            ctrl_reg <= wdata_in; // [R08] [R09] [R13]
         end
         if (addr_in == baud_gen_pkg::SERIAL_MODE_ADDR)
         begin
            mode_reg <= wdata_in;
         end
      end
   end

   // Read data one cycle after the read strobe, zero otherwise
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rdata_out <= 8'h00;
      end
      else if (rd_in)
      begin
         case (addr_in)
            baud_gen_pkg::BAUD_DIVIDER_CONTROL_ADDR: rdata_out <= ctrl_reg;
            baud_gen_pkg::SERIAL_MODE_ADDR: rdata_out <= {mode_reg[7:5], 5'h00};
            baud_gen_pkg::STATUS_ADDR: rdata_out <= status_word;
            default: rdata_out <= 8'h00;
         endcase
      end
      else
      begin
         rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------
   // Base clock source and gating
   // ----------------------------------------
   // Free prescaler giving /2, /8, /32 enables
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         prescale_reg <= 5'h00;
         timer_prev_reg <= 1'b0;
      end
      else
      begin
         prescale_reg <= prescale_reg + 5'h01;
         timer_prev_reg <= timer_channel_output_in;
      end
   end

   // Select one-cycle base enable from the chosen source
   always_comb
   begin
      case (ctrl_reg.clock_select) // [R08]
         baud_gen_pkg::SEL_TIMER: base_src = timer_channel_output_in & ~timer_prev_reg;
         baud_gen_pkg::SEL_DIV2: base_src = prescale_reg[0];
         baud_gen_pkg::SEL_DIV8: base_src = (prescale_reg[2:0] == 3'h7);
         baud_gen_pkg::SEL_DIV32: base_src = (prescale_reg == baud_gen_pkg::PRESCALE_MAX);
         default: base_src = 1'b0;
      endcase
   end

   // Base enable only while the serial power bit is set
   assign base_en = base_src & mode_reg.serial_power_bit; // [R01]

   // Visible base clock, held low while unpowered
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         base_clock_out <= 1'b0;
      end
      else
      begin
         base_clock_out <= base_en; // [R01]
      end
   end

   // ----------------------------------------
   // Transmit bit-timing counter
   // ----------------------------------------
   // Counts k base clocks twice per bit; cleared by first data write
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tx_count_reg <= 5'h00;
         tx_half_reg <= 1'b0;
         tx_bit_tick_out <= 1'b0;
      end
      else if (!tx_run)
      begin
         tx_count_reg <= 5'h00; // [R02]
         tx_half_reg <= 1'b0;
         tx_bit_tick_out <= 1'b0;
      end
      else if (tx_write && tx_first_reg)
      begin
         tx_count_reg <= 5'h00; // [R04]
         tx_half_reg <= 1'b0;
         tx_bit_tick_out <= 1'b0;
      end
      else if (base_en)
      begin
         // Divisor below the minimum is unsupported and wraps freely [R16]
         if (tx_count_reg >= k_last)
         begin
            tx_count_reg <= 5'h00; // [R03] [R15]
            tx_half_reg <= ~tx_half_reg;
            tx_bit_tick_out <= tx_half_reg; // [R10]
         end
         else
         begin
            tx_count_reg <= tx_count_reg + 5'h01;
            tx_bit_tick_out <= 1'b0;
         end
      end
      else
      begin
         tx_bit_tick_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // First-write flag
   // ----------------------------------------
   // Pending until the first data write; re-arm beats a write in the same cycle
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tx_first_reg <= 1'b1;
      end
      else if (!tx_run)
      begin
         tx_first_reg <= 1'b1;
      end
      else if (tx_write)
      begin
         tx_first_reg <= 1'b0; // [R04]
      end
   end

   // ----------------------------------------
   // Receive start detection
   // ----------------------------------------
   // Line level at the previous base clock; resets to the idle high level
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rxd_prev_reg <= 1'b1;
      end
      else if (base_en)
      begin
         rxd_prev_reg <= rxd_in;
      end
   end

   // ----------------------------------------
   // Receive bit-timing counter and frame control
   // ----------------------------------------
   // Falling edge starts a k-count check, then bits latched at mid-bit
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rx_state_reg <= baud_gen_pkg::RX_IDLE;
         rx_count_reg <= 5'h00;
         rx_half_reg <= 1'b0;
         rx_bits_reg <= 4'h0;
         rx_sample_out <= 1'b0;
         rx_bit_out <= 1'b1;
         rx_busy_out <= 1'b0;
      end
      else if (!rx_run)
      begin
         rx_state_reg <= baud_gen_pkg::RX_IDLE; // [R05]
         rx_count_reg <= 5'h00;
         rx_half_reg <= 1'b0;
         rx_bits_reg <= 4'h0;
         rx_sample_out <= 1'b0;
         rx_busy_out <= 1'b0;
      end
      else
      begin
         rx_sample_out <= 1'b0;
         case (rx_state_reg)
            baud_gen_pkg::RX_IDLE:
            begin
               rx_count_reg <= 5'h00; // [R07]
               rx_half_reg <= 1'b0;
               rx_bits_reg <= 4'h0;
               rx_busy_out <= 1'b0;
               if (rx_start)
               begin
                  rx_state_reg <= baud_gen_pkg::RX_VERIFY; // [R06]
                  rx_busy_out <= 1'b1;
               end
            end
            baud_gen_pkg::RX_VERIFY:
            begin
               if (base_en)
               begin
                  if (rx_count_reg >= k_last)
                  begin
                     rx_count_reg <= 5'h00;
                     if (!rxd_in)
                     begin
                        rx_state_reg <= baud_gen_pkg::RX_FRAME; // [R06] [R15]
                        rx_half_reg <= 1'b0;
                     end
                     else
                     begin
                        rx_state_reg <= baud_gen_pkg::RX_IDLE;
                     end
                  end
                  else
                  begin
                     rx_count_reg <= rx_count_reg + 5'h01;
                  end
               end
            end
            baud_gen_pkg::RX_FRAME:
            begin
               if (base_en)
               begin
                  if (rx_count_reg >= k_last)
                  begin
                     rx_count_reg <= 5'h00;
                     rx_half_reg <= ~rx_half_reg;
                     if (rx_half_reg)
                     begin
                        // Mid-bit latch each 2k base clocks [R10] [R11] [R12]
                        rx_sample_out <= 1'b1;
                        rx_bit_out <= rxd_in;
                        rx_bits_reg <= rx_bits_reg + 4'h1;
                        if (rx_bits_reg == 4'(FRAME_LEN - 2))
                        begin
                           rx_state_reg <= baud_gen_pkg::RX_IDLE; // [R07]
                        end
                     end
                  end
                  else
                  begin
                     rx_count_reg <= rx_count_reg + 5'h01;
                  end
               end
            end
            default:
            begin
               rx_state_reg <= baud_gen_pkg::RX_IDLE;
            end
         endcase
      end
   end
endmodule : uart_baud_rate_generator

// ==== test/rx_partner.sv ====
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ns
module rx_partner (
   input wire logic mclk_in,
   output logic rxd_out
);
   // Line idles high between frames
   initial rxd_out = 1'b1;
   // Start, eight data bits LSB first, parity, stop; bl cycles per bit
   task automatic send(input logic [7:0] d, input int bl);
      logic [10:0] f;
      f = {1'b1, ^d, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         rxd_out <= f[i];
         repeat (bl) @(posedge mclk_in);
      end
   endtask : send
endmodule : rx_partner

// ==== test/uart_baud_rate_generator_monitor.sv ====
// Port checker of the baud rate generator
`timescale 1ns/1ns
module uart_baud_rate_generator_monitor #(
   parameter int FRAME_LEN = 11
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic timer_channel_output_in,
   input wire logic rxd_in,
   input wire logic [7:0] rdata_out,
   input wire logic base_clock_out,
   input wire logic tx_bit_tick_out,
   input wire logic rx_sample_out,
   input wire logic rx_bit_out,
   input wire logic rx_busy_out
);
   logic [7:0] ctl_reg;
   logic [2:0] mode_reg;
   logic [3:0] cnt_reg;
   wire tx_on = mode_reg[2] & mode_reg[1];
   wire rx_on = mode_reg[2] & mode_reg[0];
   // Shadow of control and mode as written over the port
   always_ff @(posedge mclk_in or negedge reset_n_in)
      if (!reset_n_in)
      begin
         ctl_reg <= 8'h1F;
         mode_reg <= 3'h0;
      end
      else if (wr_in)
      begin
         if (addr_in == 2'h0)
            ctl_reg <= wdata_in;
         if (addr_in == 2'h1)
            mode_reg <= wdata_in[7:5];
      end
   // Samples taken in the current frame
   always_ff @(posedge mclk_in or negedge reset_n_in)
      if (!reset_n_in)
         cnt_reg <= 4'h0;
      else if (rx_sample_out)
         cnt_reg <= cnt_reg + 4'h1;
      else if (!rx_busy_out)
         cnt_reg <= 4'h0;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_gate; !mode_reg[2] && !$past(mode_reg[2]) |-> !base_clock_out; endproperty
   a_gate: assert property (p_gate) else $error("base clock while off");
   property p_txoff; !tx_on && !$past(tx_on) |-> !tx_bit_tick_out; endproperty
   a_txoff: assert property (p_txoff) else $error("tick while off");
   property p_rxoff; !rx_on && !$past(rx_on) |-> !rx_busy_out; endproperty
   a_rxoff: assert property (p_rxoff) else $error("busy while off");
   property p_samp; rx_sample_out |-> $past(rx_busy_out); endproperty
   a_samp: assert property (p_samp) else $error("sample outside frame");
   property p_cnt; rx_sample_out |-> cnt_reg < FRAME_LEN - 1; endproperty
   a_cnt: assert property (p_cnt) else $error("too many samples");
   property p_div2; ctl_reg[7:6] == 2'h1 && mode_reg[2] && $past(mode_reg[2], 3)
      && $past(ctl_reg[7:6], 3) == 2'h1 |-> base_clock_out || $past(base_clock_out); endproperty
   a_div2: assert property (p_div2) else $error("base clock gap");
   property p_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_ctl; $past(rd_in && addr_in == 2'h0) |-> rdata_out == $past(ctl_reg); endproperty
   a_ctl: assert property (p_ctl) else $error("control readback");
endmodule : uart_baud_rate_generator_monitor
bind uart_baud_rate_generator uart_baud_rate_generator_monitor #(.FRAME_LEN(FRAME_LEN)) mon (.*);

// ==== test/tb_uart_baud_rate_generator.sv ====
// Self-checking bench of the baud rate generator
`timescale 1ns/1ns
module tb_uart_baud_rate_generator;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [1:0] addr_in = 2'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic base_clock_out, tx_bit_tick_out, rx_sample_out, rx_bit_out, rx_busy_out, rxd;
   logic [15:0] cyc = 16'h0000;
   logic [9:0] rxs = 10'h000;
   logic [7:0] d;
   int err_count = 0;
   int n_compared = 0;
   int nsamp = 0;
   int n, k, nb;
   initial forever #20 mclk_in = ~mclk_in;
   uart_baud_rate_generator dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .timer_channel_output_in(cyc[1]),
      .rxd_in(rxd), .rdata_out(rdata_out), .base_clock_out(base_clock_out),
      .tx_bit_tick_out(tx_bit_tick_out), .rx_sample_out(rx_sample_out), .rx_bit_out(rx_bit_out),
      .rx_busy_out(rx_busy_out));
   rx_partner p (.mclk_in(mclk_in), .rxd_out(rxd));
   // Cycle count, timer source, timeout and capture of latched bits
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 16'h0001;
      if (rx_sample_out)
      begin
         rxs <= {rx_bit_out, rxs[9:1]};
         nsamp++;
      end
      if (cyc == 16'h4E20)
      begin
         err_count++;
         end_of_test;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e, input string nm);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(posedge mclk_in);
      chk(rdata_out, e, nm);
   endtask : rd
   // Cycles from one transmit tick to the next
   task automatic per(output int c);
      c = 0;
      do @(posedge mclk_in); while (!tx_bit_tick_out);
      do begin @(posedge mclk_in); c++; end while (!tx_bit_tick_out);
   endtask : per
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial
   begin
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      @(posedge mclk_in);
      rd(2'h0, 8'h1F, "ctrl reset");
      rd(2'h1, 8'h00, "mode reset");
      rd(2'h3, 8'h40, "status reset");
      $display("Test reset done");
      wr(2'h0, 8'h48);
      nb = 0;
      repeat (40) begin @(posedge mclk_in); nb += base_clock_out; end
      chk(nb[15:0], 16'h0000, "base clock off");
      wr(2'h1, 8'h80);
      n = 0;
      nb = 0;
      repeat (200) begin @(posedge mclk_in); n += tx_bit_tick_out; nb += base_clock_out; end
      chk(n[15:0], 16'h0000, "tick off");
      chk(nb[15:0], 16'h0064, "base clock on");
      $display("Test transmit hold done");
      wr(2'h1, 8'hC0);
      for (int s = 0; s < 4; s++)
      begin
         k = (s == 3) ? 31 : 8 + s;
         wr(2'h0, {s[1:0], 1'b0, k[4:0]});
         rd(2'h0, {s[1:0], 1'b0, k[4:0]}, "ctrl");
         per(n);
         per(n);
         chk(n[15:0], 16'(2 * k * (s ? 1 << (2 * s - 1) : 4)), "bit period");
      end
      $display("Test sources done");
      wr(2'h0, 8'h48);
      for (int i = 0; i < 2; i++)
      begin
         per(n);
         repeat (14) @(posedge mclk_in);
         wr(2'h2, 8'h55);
         n = 0;
         do begin @(posedge mclk_in); n++; end while (!tx_bit_tick_out);
         chk(n >= 29, i == 0, "first write realign");
      end
      rd(2'h3, 8'h00, "first write flag");
      $display("Test transmit write done");
      wr(2'h1, 8'h80);
      nsamp = 0;
      p.send(8'hA5, 32);
      chk(nsamp[15:0], 16'h0000, "rx off");
      wr(2'h1, 8'hA0);
      for (int i = 0; i < 2; i++)
      begin
         d = i ? 8'hC5 : 8'h3C;
         nsamp = 0;
         p.send(d, i ? 33 : 31);
         repeat (100) @(posedge mclk_in);
         chk(nsamp[15:0], 16'h000A, "samples");
         chk(rxs, {1'b1, ^d, d}, "rx bits");
         chk(rx_busy_out, 1'b0, "rx idle");
      end
      $display("Test receive done");
      end_of_test;
   end
endmodule : tb_uart_baud_rate_generator
